// >>> rtl/sva_pkg.sv
// package of constants for the supervisor block
package sva_pkg;
  localparam int POWER_LOG_DEPTH = 1024;
  localparam int SYSTEM_LOG_DEPTH = 2048;
  localparam int SLOTS = 12;
  localparam int POINTS = 8;
  localparam int LOG_WIDTH = 32;
  // register byte offsets
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CRIT_CODE = 8'h08;
  localparam logic [7:0] ADDR_MINOR_CODE = 8'h0C;
  localparam logic [7:0] ADDR_MASK_SET = 8'h10;
  localparam logic [7:0] ADDR_MASK_CLR = 8'h14;
  localparam logic [7:0] ADDR_SKIP_SET = 8'h18;
  localparam logic [7:0] ADDR_SKIP_CLR = 8'h1C;
  localparam logic [7:0] ADDR_MASK_INFO = 8'h20;
  localparam logic [7:0] ADDR_SKIP_INFO = 8'h24;
  localparam logic [7:0] ADDR_MODULE_ERR = 8'h28;
  localparam logic [7:0] ADDR_POWER_COUNT = 8'h2C;
  localparam logic [7:0] ADDR_SYSTEM_COUNT = 8'h30;
  localparam logic [7:0] ADDR_POWER_READ = 8'h34;
  localparam logic [7:0] ADDR_SYSTEM_READ = 8'h38;
  localparam logic [7:0] ADDR_LOG_INDEX = 8'h3C;
  // control register bits (write-one pulses except check flags)
  localparam int CTL_CRIT_CHECK = 0;
  localparam int CTL_MINOR_CHECK = 1;
  localparam int CTL_SCAN_DONE = 2;
  localparam int CTL_CLEAR_POWER_LOG = 3;
  localparam int CTL_CLEAR_SYSTEM_LOG = 4;
  localparam int CTL_CLEAR_CPU_ERR = 5;
  // status register bits
  localparam int ST_ANN_ERROR = 0;
  localparam int ST_ANN_WARNING = 1;
  localparam int ST_MASK_ACTIVE = 2;
  localparam int ST_SYS_ERROR = 3;
  localparam int ST_CPU_ERR = 4;
  localparam int ST_MODULE_ERR = 5;
  localparam int ST_SYS_STOP = 6;
  // reset key long-press time and derived count
  localparam int CLOCK_HZ = 50_000_000;
  localparam int RESET_KEY_LONG_S = 3;
  localparam longint RESET_KEY_LONG_CYCLES = longint'(RESET_KEY_LONG_S) * CLOCK_HZ;
  localparam logic [LOG_WIDTH-1:0] RESET_WORD = 32'h0000_0000;
endpackage

// >>> rtl/sva_supervisor.sv
// supervisor: history logs, annunciators, fault mask and i/o skip
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps
// How it works
// - log each power on/off with state in bit 0 and timestamp bits 31:1, keep 1024 entries
// - log system events with timestamp and contents, keep 2048 entries
// - log entries persist; only an explicit delete command erases them
// - nonzero critical code plus check flag raises error, outputs off, error state
// - nonzero minor code plus check flag raises warning, code kept, run continues
// - minor condition removed: code and warning cleared after next scan
// - masked slot error stops only that module, system keeps running
// - any module error outside a skipped slot sets module error flag and power status indicator
// - read-only per-base masked slot word and mask active flag
// - mask clears only by release command, backup loss, overall reset or long reset key press
// - mask survives power cycle, mode change, download, short reset key
// - mask release while cpu error flag set stops the system
// - skipped module gets no refresh and no error diagnosis
// - skipped input holds prior image, forced points still apply
// - skipped output pins off, force ignored, image follows program
// - direct instruction access obeys skip the same as scan refresh
// - skip selectable per module
// - skip clears like mask and survives the same events
// - forced input points replace module data at input refresh
module sva_supervisor #(
  parameter int SLOTS = sva_pkg::SLOTS,
  parameter int POINTS = sva_pkg::POINTS,
  parameter int POWER_DEPTH = sva_pkg::POWER_LOG_DEPTH,
  parameter int SYSTEM_DEPTH = sva_pkg::SYSTEM_LOG_DEPTH,
  parameter bit LOG_OVERWRITE = 1'b0,
  parameter longint RESET_KEY_LONG = sva_pkg::RESET_KEY_LONG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] timestamp,
  input wire logic powerEvent,
  input wire logic powerOn,
  input wire logic systemEvent,
  input wire logic [15:0] systemContents,
  input wire logic overallReset,
  input wire logic backupLost,
  input wire logic resetKey,
  input wire logic inputRefresh,
  input wire logic outputRefresh,
  input wire logic [SLOTS-1:0] directAccess,
  input wire logic [SLOTS-1:0] moduleErrorPin,
  input wire logic [SLOTS*POINTS-1:0] moduleInData,
  input wire logic [SLOTS*POINTS-1:0] forceInEnable,
  input wire logic [SLOTS*POINTS-1:0] forceInValue,
  input wire logic [SLOTS*POINTS-1:0] forceOutEnable,
  input wire logic [SLOTS*POINTS-1:0] forceOutValue,
  input wire logic [SLOTS*POINTS-1:0] outputImage,
  output logic [SLOTS*POINTS-1:0] inputImage,
  output logic [SLOTS*POINTS-1:0] moduleOutData,
  output logic [SLOTS-1:0] moduleRun,
  output logic allOutputsOff,
  output logic annunciator_error,
  output logic annunciator_warning,
  output logic power_status_indicator,
  output logic systemStop
);
  localparam int PW = $clog2(POWER_DEPTH);
  localparam int SW = $clog2(SYSTEM_DEPTH);
  localparam int KW = 64;

  // synchronised pins
  logic [4:0] pinMeta_reg, pinSync_reg;
  logic [SLOTS-1:0] errMeta_reg, errSync_reg;
  logic [SLOTS*POINTS-1:0] inMeta_reg, inSync_reg;
  logic [3:0] pinPrev_reg;
  wire logic [4:0] pinRaw = {powerOn, resetKey, backupLost, systemEvent, powerEvent};
  wire logic powerEdge = pinSync_reg[0] & ~pinPrev_reg[0];
  wire logic systemEdge = pinSync_reg[1] & ~pinPrev_reg[1];
  wire logic backupLoss = pinSync_reg[2];
  wire logic keyHeld = pinSync_reg[3];
  wire logic powerSync_on = pinSync_reg[4];

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinMeta_reg <= 5'h00;
      pinSync_reg <= 5'h00;
      pinPrev_reg <= 4'h0;
      errMeta_reg <= '0;
      errSync_reg <= '0;
      inMeta_reg <= '0;
      inSync_reg <= '0;
    end else begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg[3:0];
      errMeta_reg <= moduleErrorPin;
      errSync_reg <= errMeta_reg;
      inMeta_reg <= moduleInData;
      inSync_reg <= inMeta_reg;
    end
  end

  // apb decode
  wire logic access = psel & penable;
  wire logic wrAcc = access & pwrite;
  wire logic rdAcc = access & ~pwrite;
  logic mapped;

  // persistent supervisor state
  logic [15:0] critCode_reg, critCode_next;
  logic [15:0] minorCode_reg, minorCode_next;
  logic critCheck_reg, critCheck_next;
  logic minorCheck_reg, minorCheck_next;
  logic errState_reg, errState_next;
  logic warn_reg, warn_next;
  logic minorSeen_reg, minorSeen_next;
  logic [SLOTS-1:0] mask_reg, mask_next;
  logic [SLOTS-1:0] skip_reg, skip_next;
  logic [SLOTS-1:0] modErr_reg, modErr_next;
  logic [SLOTS-1:0] stopped_reg, stopped_next;
  logic cpuErr_reg, cpuErr_next;
  logic sysStop_reg, sysStop_next;
  logic [KW-1:0] keyCount_reg, keyCount_next;
  logic longKey_reg, longKey_next;
  logic [SLOTS*POINTS-1:0] inImg_reg, inImg_next;
  logic [SLOTS*POINTS-1:0] outPin_reg, outPin_next;
  logic [31:0] prdata_next;

  // history logs
  localparam int LOG_WIDTH_T = sva_pkg::LOG_WIDTH + 16;
  logic [LOG_WIDTH_T-1:0] powerMem [POWER_DEPTH];
  logic [LOG_WIDTH_T-1:0] systemMem [SYSTEM_DEPTH];
  logic [PW:0] powerCount_reg, powerCount_next;
  logic [SW:0] systemCount_reg, systemCount_next;
  logic [PW-1:0] powerPtr_reg, powerPtr_next;
  logic [SW-1:0] systemPtr_reg, systemPtr_next;
  logic [SW-1:0] logIndex_reg, logIndex_next;
  logic powerWrite, systemWrite;

  wire logic wipe = overallReset | backupLoss | longKey_reg;
  wire logic [SLOTS-1:0] diagErr = errSync_reg & ~skip_reg;

  always_comb begin
    powerWrite = powerEdge && (LOG_OVERWRITE || powerCount_reg < (PW+1)'(POWER_DEPTH));
    systemWrite = systemEdge && (LOG_OVERWRITE || systemCount_reg < (SW+1)'(SYSTEM_DEPTH));
  end

  always_comb begin
    critCode_next = critCode_reg;
    minorCode_next = minorCode_reg;
    critCheck_next = critCheck_reg;
    minorCheck_next = minorCheck_reg;
    errState_next = errState_reg;
    warn_next = warn_reg;
    minorSeen_next = minorSeen_reg;
    mask_next = mask_reg;
    skip_next = skip_reg;
    modErr_next = modErr_reg | diagErr;
    stopped_next = stopped_reg;
    cpuErr_next = cpuErr_reg;
    sysStop_next = sysStop_reg;
    keyCount_next = keyHeld ? keyCount_reg + 64'h1 : 64'h0;
    longKey_next = keyHeld && keyCount_reg >= 64'(RESET_KEY_LONG - 1);
    powerCount_next = powerCount_reg;
    systemCount_next = systemCount_reg;
    powerPtr_next = powerPtr_reg;
    systemPtr_next = systemPtr_reg;
    logIndex_next = logIndex_reg;
    for (int s = 0; s < SLOTS; s++) begin
      if (diagErr[s]) begin
        if (mask_reg[s]) stopped_next[s] = 1'b1;
        else cpuErr_next = 1'b1;
      end
    end
    if (wrAcc) begin
      case (paddr)
        sva_pkg::ADDR_CONTROL: begin
          critCheck_next = pwdata[sva_pkg::CTL_CRIT_CHECK];
          minorCheck_next = pwdata[sva_pkg::CTL_MINOR_CHECK];
          if (pwdata[sva_pkg::CTL_SCAN_DONE]) begin
            if (!minorCheck_reg && minorSeen_reg) begin
              minorCode_next = 16'h0000;
              warn_next = 1'b0;
              minorSeen_next = 1'b0;
            end
          end
          if (pwdata[sva_pkg::CTL_CLEAR_POWER_LOG]) begin
            powerCount_next = '0;
            powerPtr_next = '0;
          end
          if (pwdata[sva_pkg::CTL_CLEAR_SYSTEM_LOG]) begin
            systemCount_next = '0;
            systemPtr_next = '0;
          end
          if (pwdata[sva_pkg::CTL_CLEAR_CPU_ERR] && diagErr == '0) cpuErr_next = 1'b0;
        end
        sva_pkg::ADDR_CRIT_CODE: critCode_next = pwdata[15:0];
        sva_pkg::ADDR_MINOR_CODE: minorCode_next = pwdata[15:0];
        sva_pkg::ADDR_MASK_SET: mask_next = mask_reg | pwdata[SLOTS-1:0];
        sva_pkg::ADDR_MASK_CLR: begin
          mask_next = mask_reg & ~pwdata[SLOTS-1:0];
          stopped_next = stopped_next & ~pwdata[SLOTS-1:0];
          if ((pwdata[SLOTS-1:0] & mask_reg) != '0 && cpuErr_reg) sysStop_next = 1'b1;
        end
        sva_pkg::ADDR_SKIP_SET: skip_next = skip_reg | pwdata[SLOTS-1:0];
        sva_pkg::ADDR_SKIP_CLR: skip_next = skip_reg & ~pwdata[SLOTS-1:0];
        sva_pkg::ADDR_LOG_INDEX: logIndex_next = pwdata[SW-1:0];
        default: begin
        end
      endcase
    end
    if (critCheck_next && critCode_next != 16'h0000) errState_next = 1'b1;
    if (minorCheck_next && minorCode_next != 16'h0000) begin
      warn_next = 1'b1;
      minorSeen_next = 1'b1;
    end
    if (powerWrite) begin
      powerPtr_next = powerPtr_reg + PW'(1);
      if (powerCount_reg < (PW+1)'(POWER_DEPTH)) powerCount_next = powerCount_reg + (PW+1)'(1);
    end
    if (systemWrite) begin
      systemPtr_next = systemPtr_reg + SW'(1);
      if (systemCount_reg < (SW+1)'(SYSTEM_DEPTH)) systemCount_next = systemCount_reg + (SW+1)'(1);
    end
    if (wipe) begin
      mask_next = '0;
      skip_next = '0;
      stopped_next = '0;
    end
  end

  // i/o image path
  always_comb begin
    inImg_next = inImg_reg;
    outPin_next = outPin_reg;
    for (int s = 0; s < SLOTS; s++) begin
      for (int p = 0; p < POINTS; p++) begin
        if ((inputRefresh || directAccess[s]) && !skip_reg[s] && !stopped_reg[s]) begin
          inImg_next[s*POINTS+p] = forceInEnable[s*POINTS+p] ?
            forceInValue[s*POINTS+p] : inSync_reg[s*POINTS+p];
        end else if (forceInEnable[s*POINTS+p]) begin
          inImg_next[s*POINTS+p] = forceInValue[s*POINTS+p];
        end
        if (skip_reg[s] || stopped_reg[s] || errState_reg || sysStop_reg) begin
          outPin_next[s*POINTS+p] = 1'b0;
        end else if (outputRefresh || directAccess[s]) begin
          outPin_next[s*POINTS+p] = forceOutEnable[s*POINTS+p] ?
            forceOutValue[s*POINTS+p] : outputImage[s*POINTS+p];
        end
      end
    end
  end

  // read mux
  always_comb begin
    mapped = 1'b1;
    prdata_next = 32'h0000_0000;
    case (paddr)
      sva_pkg::ADDR_CONTROL: prdata_next = {30'h0, minorCheck_reg, critCheck_reg};
      sva_pkg::ADDR_STATUS: begin
        prdata_next[sva_pkg::ST_ANN_ERROR] = errState_reg;
        prdata_next[sva_pkg::ST_ANN_WARNING] = warn_reg;
        prdata_next[sva_pkg::ST_MASK_ACTIVE] = |mask_reg;
        prdata_next[sva_pkg::ST_SYS_ERROR] = errState_reg | sysStop_reg;
        prdata_next[sva_pkg::ST_CPU_ERR] = cpuErr_reg;
        prdata_next[sva_pkg::ST_MODULE_ERR] = |modErr_reg;
        prdata_next[sva_pkg::ST_SYS_STOP] = sysStop_reg;
      end
      sva_pkg::ADDR_CRIT_CODE: prdata_next = {16'h0000, critCode_reg};
      sva_pkg::ADDR_MINOR_CODE: prdata_next = {16'h0000, minorCode_reg};
      sva_pkg::ADDR_MASK_INFO: prdata_next[SLOTS-1:0] = mask_reg;
      sva_pkg::ADDR_SKIP_INFO: prdata_next[SLOTS-1:0] = skip_reg;
      sva_pkg::ADDR_MODULE_ERR: prdata_next[SLOTS-1:0] = modErr_reg;
      sva_pkg::ADDR_POWER_COUNT: prdata_next[PW:0] = powerCount_reg;
      sva_pkg::ADDR_SYSTEM_COUNT: prdata_next[SW:0] = systemCount_reg;
      sva_pkg::ADDR_POWER_READ: prdata_next = powerMem[logIndex_reg[PW-1:0]][31:0];
      sva_pkg::ADDR_SYSTEM_READ: prdata_next = {systemMem[logIndex_reg][47:32], systemMem[logIndex_reg][15:0]};
      sva_pkg::ADDR_LOG_INDEX: prdata_next[SW-1:0] = logIndex_reg;
      sva_pkg::ADDR_MASK_SET, sva_pkg::ADDR_MASK_CLR, sva_pkg::ADDR_SKIP_SET, sva_pkg::ADDR_SKIP_CLR: begin
      end
      default: mapped = 1'b0;
    endcase
  end

  // log memories, no reset
  always_ff @(posedge ref_clk) begin
    if (powerWrite) powerMem[powerPtr_reg] <= {16'h0000, timestamp[31:1], powerSync_on};
    if (systemWrite) systemMem[systemPtr_reg] <= {systemContents, timestamp};
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      critCode_reg <= 16'h0000;
      minorCode_reg <= 16'h0000;
      critCheck_reg <= 1'b0;
      minorCheck_reg <= 1'b0;
      errState_reg <= 1'b0;
      warn_reg <= 1'b0;
      minorSeen_reg <= 1'b0;
      mask_reg <= '0;
      skip_reg <= '0;
      modErr_reg <= '0;
      stopped_reg <= '0;
      cpuErr_reg <= 1'b0;
      sysStop_reg <= 1'b0;
      keyCount_reg <= 64'h0;
      longKey_reg <= 1'b0;
      inImg_reg <= '0;
      outPin_reg <= '0;
      powerCount_reg <= '0;
      systemCount_reg <= '0;
      powerPtr_reg <= '0;
      systemPtr_reg <= '0;
      logIndex_reg <= '0;
      prdata <= 32'h0000_0000;
    end else begin
      critCode_reg <= critCode_next;
      minorCode_reg <= minorCode_next;
      critCheck_reg <= critCheck_next;
      minorCheck_reg <= minorCheck_next;
      errState_reg <= errState_next;
      warn_reg <= warn_next;
      minorSeen_reg <= minorSeen_next;
      mask_reg <= mask_next;
      skip_reg <= skip_next;
      modErr_reg <= modErr_next;
      stopped_reg <= stopped_next;
      cpuErr_reg <= cpuErr_next;
      sysStop_reg <= sysStop_next;
      keyCount_reg <= keyCount_next;
      longKey_reg <= longKey_next;
      inImg_reg <= inImg_next;
      outPin_reg <= outPin_next;
      powerCount_reg <= powerCount_next;
      systemCount_reg <= systemCount_next;
      powerPtr_reg <= powerPtr_next;
      systemPtr_reg <= systemPtr_next;
      logIndex_reg <= logIndex_next;
      prdata <= rdAcc ? prdata_next : prdata;
    end
  end

  // outputs
  always_comb begin
    pready = 1'b1;
    pslverr = access & ~mapped;
    inputImage = inImg_reg;
    moduleOutData = outPin_reg;
    moduleRun = ~(stopped_reg | skip_reg);
    allOutputsOff = errState_reg | sysStop_reg;
    annunciator_error = errState_reg;
    annunciator_warning = warn_reg;
    power_status_indicator = |modErr_reg;
    systemStop = errState_reg | sysStop_reg;
  end
endmodule

// >>> sim/sva_io_base_model.sv
// model of the i/o modules on the base
`timescale 1ns/100ps
module sva_io_base_model #(
  parameter int SLOTS = 12,
  parameter int POINTS = 8
) (
  input wire logic ref_clk,
  input wire logic [POINTS-1:0] pattern,
  input wire logic [SLOTS-1:0] errSlots,
  output logic [SLOTS*POINTS-1:0] moduleInData,
  output logic [SLOTS-1:0] moduleErrorPin
);
  // every module presents the same input pattern
  always @(posedge ref_clk) begin
    moduleInData <= {SLOTS{pattern}};
    moduleErrorPin <= errSlots;
  end
endmodule

// >>> sim/sva_supervisor_monitor.sv
// checker for supervisor port behaviour
`timescale 1ns/100ps
module sva_supervisor_monitor #(
  parameter int SLOTS = 12,
  parameter int POINTS = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SLOTS*POINTS-1:0] moduleOutData,
  input wire logic allOutputsOff,
  input wire logic annunciator_error,
  input wire logic annunciator_warning,
  input wire logic systemStop
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  AST_PREADY: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  AST_SLVERR_PHASE: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  AST_SLVERR_MAPPED: assert property (psel && penable && paddr <= 8'h3C && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("pslverr on mapped register");
  AST_SLVERR_UNMAPPED: assert property (psel && penable && paddr > 8'h3C |-> pslverr)
    else $error("no pslverr on unmapped address");
  AST_ERR_OFF: assert property (annunciator_error |-> allOutputsOff ##2 moduleOutData == '0)
    else $error("error annunciator without outputs off");
  AST_ERR_HOLD: assert property (annunciator_error |=> annunciator_error)
    else $error("error state left without reset");
  AST_OUT_OFF: assert property (allOutputsOff [*3] |-> moduleOutData == '0)
    else $error("module outputs on while outputs off");
  AST_WARN_RUN: assert property (annunciator_warning && !annunciator_error && !systemStop |-> !allOutputsOff)
    else $error("warning stopped the outputs");
  AST_STOP_HOLD: assert property ($rose(systemStop) |=> systemStop [*3])
    else $error("system stop did not persist");
  cover property ($rose(annunciator_error));
  cover property ($rose(annunciator_warning));
  cover property ($rose(systemStop));
  cover property (pslverr);
endmodule

// >>> sim/sva_supervisor_tb_top.sv
// testbench for the supervisor block
`timescale 1ns/100ps
module sva_supervisor_tb_top;
  localparam int S = sva_pkg::SLOTS;
  localparam int P = sva_pkg::POINTS;
  localparam int PD = 4;
  logic ref_clk, arst_n, psel, penable, pwrite, powerEvent, powerOn, systemEvent, lastErr;
  logic overallReset, resetKey, backupLost, inputRefresh, outputRefresh, pready, pslverr;
  logic allOutputsOff, annunciator_error, annunciator_warning, power_status_indicator, systemStop;
  logic [7:0] paddr, pattern;
  logic [31:0] pwdata, prdata, timestamp;
  logic [15:0] systemContents;
  logic [S-1:0] directAccess, errSlots, moduleErrorPin, moduleRun;
  logic [S*P-1:0] moduleInData, forceInEnable, forceInValue, forceOutEnable, outputImage, inputImage, moduleOutData;
  int mismatches, compares;
  sva_supervisor #(.POWER_DEPTH(PD), .RESET_KEY_LONG(20)) sva_supervisor_inst (.ref_clk, .arst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timestamp, .powerEvent, .powerOn,
    .systemEvent, .systemContents, .overallReset, .backupLost, .resetKey, .inputRefresh, .outputRefresh,
    .directAccess, .moduleErrorPin, .moduleInData, .forceInEnable, .forceInValue, .forceOutEnable,
    .forceOutValue({S*P{1'b1}}), .outputImage, .inputImage, .moduleOutData, .moduleRun, .allOutputsOff,
    .annunciator_error, .annunciator_warning, .power_status_indicator, .systemStop);
  sva_io_base_model #(.SLOTS(S), .POINTS(P)) sva_io_base_model_inst (.ref_clk, .pattern, .errSlots,
    .moduleInData, .moduleErrorPin);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) timestamp <= arst_n ? timestamp + 32'h1 : 32'h0;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    tick(1);
    while (pready !== 1'b1) tick(1);
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, e, prdata);
  endtask
  task automatic pulseRefresh();
    tick(3);
    inputRefresh <= 1'b1;
    outputRefresh <= 1'b1;
    tick(1);
    inputRefresh <= 1'b0;
    outputRefresh <= 1'b0;
    tick(3);
  endtask
  task automatic close_out();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(5000);
    mismatches++;
    close_out();
  end
  initial begin
    {arst_n, psel, penable, pwrite, powerEvent, powerOn, systemEvent, overallReset, resetKey, backupLost} = '0;
    {inputRefresh, outputRefresh, paddr, pattern, pwdata, systemContents} = '0;
    {directAccess, errSlots, forceInEnable, forceInValue, forceOutEnable, outputImage} = '0;
    tick(5);
    arst_n <= 1'b1;
    tick(1);
    check("run", 32'hFFF, 32'(moduleRun));
    rd(sva_pkg::ADDR_MASK_INFO, 32'h0, "maskInfo");
    rd(8'h40, 32'h0, "unmapped");
    check("unmappedErr", 32'h1, 32'(lastErr));
    for (int i = 0; i <= PD; i++) begin
      powerOn <= ~powerOn;
      powerEvent <= 1'b1;
      tick(4);
      powerEvent <= 1'b0;
      tick(4);
    end
    systemContents <= 16'h00A5;
    systemEvent <= 1'b1;
    tick(4);
    systemEvent <= 1'b0;
    tick(4);
    rd(sva_pkg::ADDR_POWER_COUNT, PD, "powerCount");
    rd(sva_pkg::ADDR_SYSTEM_COUNT, 32'h1, "systemCount");
    apb(1'b0, sva_pkg::ADDR_POWER_READ, 32'h0);
    check("powerOnLog", 32'h1, 32'(prdata[0]));
    apb(1'b0, sva_pkg::ADDR_SYSTEM_READ, 32'h0);
    check("systemLog", 32'h00A5, 32'(prdata[31:16]));
    apb(1'b1, sva_pkg::ADDR_LOG_INDEX, 32'h1);
    apb(1'b0, sva_pkg::ADDR_POWER_READ, 32'h0);
    check("powerOffLog", 32'h0, 32'(prdata[0]));
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h8);
    rd(sva_pkg::ADDR_POWER_COUNT, 32'h0, "powerCleared");
    rd(sva_pkg::ADDR_SYSTEM_COUNT, 32'h1, "systemKept");
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h10);
    rd(sva_pkg::ADDR_SYSTEM_COUNT, 32'h0, "systemCleared");
    apb(1'b1, sva_pkg::ADDR_MINOR_CODE, 32'h64);
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h2);
    check("warn", 32'h1, 32'(annunciator_warning));
    check("warnOuts", 32'h0, 32'(allOutputsOff));
    rd(sva_pkg::ADDR_MINOR_CODE, 32'h64, "minorCode");
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h0);
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h4);
    check("warnGone", 32'h0, 32'(annunciator_warning));
    rd(sva_pkg::ADDR_MINOR_CODE, 32'h0, "minorCleared");
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h1);
    check("zeroCode", 32'h0, 32'(annunciator_error));
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h0);
    apb(1'b1, sva_pkg::ADDR_MASK_SET, 32'h8);
    rd(sva_pkg::ADDR_MASK_INFO, 32'h8, "maskSet");
    rd(sva_pkg::ADDR_STATUS, 32'h4, "maskActive");
    errSlots <= 12'h008;
    tick(6);
    check("maskedRun", 32'hFF7, 32'(moduleRun));
    check("maskedStop", 32'h0, 32'(systemStop));
    check("psi", 32'h1, 32'(power_status_indicator));
    rd(sva_pkg::ADDR_MODULE_ERR, 32'h8, "modErr");
    errSlots <= '0;
    resetKey <= 1'b1;
    tick(5);
    resetKey <= 1'b0;
    rd(sva_pkg::ADDR_MASK_INFO, 32'h8, "shortKey");
    pattern <= 8'h5A;
    tick(2);
    pulseRefresh();
    apb(1'b1, sva_pkg::ADDR_SKIP_SET, 32'h20);
    rd(sva_pkg::ADDR_SKIP_INFO, 32'h20, "skipInfo");
    check("skipRun", 32'hFD7, 32'(moduleRun));
    pattern <= 8'hC3;
    forceInEnable[5*P] <= 1'b1;
    forceInValue[5*P] <= 1'b1;
    forceInEnable[1] <= 1'b1;
    forceOutEnable[7] <= 1'b1;
    forceOutEnable[5*P+7] <= 1'b1;
    outputImage <= {S{8'h0F}};
    errSlots <= 12'h020;
    directAccess <= 12'h020;
    tick(1);
    directAccess <= '0;
    tick(1);
    pulseRefresh();
    check("skipIn", 32'h5B, 32'(inputImage[5*P +: P]));
    check("forcedIn", 32'hC1, 32'(inputImage[P-1:0]));
    check("otherIn", 32'hC3, 32'(inputImage[P +: P]));
    check("skipOut", 32'h0, 32'(moduleOutData[5*P +: P]));
    check("otherOut", 32'h8F, 32'(moduleOutData[P-1:0]));
    apb(1'b0, sva_pkg::ADDR_MODULE_ERR, 32'h0);
    check("skipErr", 32'h0, 32'(prdata[5]));
    errSlots <= '0;
    apb(1'b1, sva_pkg::ADDR_MASK_SET, 32'h20);
    apb(1'b1, sva_pkg::ADDR_SKIP_CLR, 32'h20);
    rd(sva_pkg::ADDR_SKIP_INFO, 32'h0, "skipClr");
    resetKey <= 1'b1;
    tick(25);
    resetKey <= 1'b0;
    rd(sva_pkg::ADDR_MASK_INFO, 32'h0, "longKeyMask");
    rd(sva_pkg::ADDR_SKIP_INFO, 32'h0, "longKeySkip");
    errSlots <= 12'h080;
    tick(6);
    apb(1'b0, sva_pkg::ADDR_STATUS, 32'h0);
    check("cpuErr", 32'h1, 32'(prdata[4]));
    apb(1'b1, sva_pkg::ADDR_MASK_SET, 32'h80);
    apb(1'b1, sva_pkg::ADDR_MASK_CLR, 32'h80);
    check("stop", 32'h1, 32'(systemStop));
    apb(1'b1, sva_pkg::ADDR_MASK_SET, 32'h4);
    overallReset <= 1'b1;
    tick(1);
    overallReset <= 1'b0;
    rd(sva_pkg::ADDR_MASK_INFO, 32'h0, "overallReset");
    errSlots <= '0;
    apb(1'b1, sva_pkg::ADDR_MASK_SET, 32'h4);
    backupLost <= 1'b1;
    tick(4);
    backupLost <= 1'b0;
    rd(sva_pkg::ADDR_MASK_INFO, 32'h0, "backupMask");
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h20);
    apb(1'b0, sva_pkg::ADDR_STATUS, 32'h0);
    check("cpuErrClr", 32'h0, 32'(prdata[4]));
    arst_n <= 1'b0;
    tick(2);
    arst_n <= 1'b1;
    tick(1);
    apb(1'b1, sva_pkg::ADDR_CRIT_CODE, 32'h64);
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h1);
    check("critErr", 32'h1, 32'(annunciator_error));
    check("critOff", 32'h1, 32'(allOutputsOff));
    rd(sva_pkg::ADDR_CRIT_CODE, 32'h64, "critCode");
    pulseRefresh();
    check("critPins", 32'h0, 32'(moduleOutData[P-1:0]));
    apb(1'b1, sva_pkg::ADDR_CONTROL, 32'h0);
    check("critHeld", 32'h1, 32'(annunciator_error));
    close_out();
  end
endmodule
bind sva_supervisor sva_supervisor_monitor #(.SLOTS(SLOTS), .POINTS(POINTS)) sva_supervisor_monitor_inst (
  .ref_clk, .arst_n, .psel, .penable, .paddr, .pready, .pslverr, .moduleOutData, .allOutputsOff,
  .annunciator_error, .annunciator_warning, .systemStop);
